/* File: hw/ttb_timer_bank.sv */
// Contract
// - eight 16-bit timers, each with interrupt
// - enabled timer decrements low byte per tick
// - low byte write updates latch only
// - byte reads return running counters
// - low byte at zero decrements high byte
// - timeout sets flag, enabled flag interrupts
// - timeout reloads both counters from latches
// - watchdog timeout pulls reset low two ticks
// - high byte write loads latch and counters in the same cycle
// - watchdog idle until run bit rises
// - watchdog reloads on rise, ignores fall
// - per-timer clock sources fixed by number, except timer 4
// - control bit picks timer 4 clock
// - control bit enables timer 4 output
// - two bits pick pulse pin edges
// - per-UART bit picks timer 3 or 4
// - run-enable register, bit per timer
// - writing one clears a flag once
// - flag interrupts only while enabled
`timescale 1ns/1ps
`default_nettype none
module ttb_timer_bank
  import ttb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic timer4_ext_clock_pin,
  input wire logic pulse_measure_pin,
  output logic timer4_output_pin,
  output logic timer4_output_oe,
  output logic chip_reset_pin_o,
  output logic chip_reset_pin_oe,
  output logic [7:0] timer_irq,
  output logic timer_irq_any,
  output logic [3:0] uart_baud_tick,
  output logic pulse_edge_event
);
  logic [7:0] timer_control_q, timer_run_enables_q;
  logic [7:0] timer_interrupt_flags_q, timer_interrupt_enables_q;
  logic [7:0] rdata_q;
  logic [9:0] slow_cnt_q;
  logic [3:0] prescale_q;
  logic wd_run_prev_q;
  logic t4_out_q;
  logic edge_event_q;
  ttb_wd_e wd_state_q, wd_state_d;
  logic [1:0] wd_ticks_q;

  // register decode
  wire sel_ctrl = (bus_addr == TTB_CTRL_ADDR);
  wire sel_run = (bus_addr == TTB_RUN_ADDR);
  wire sel_flag = (bus_addr == TTB_FLAG_ADDR);
  wire sel_ien = (bus_addr == TTB_IEN_ADDR);
  wire sel_cnt = (bus_addr[15:4] == TTB_CNT_BASE_HI);
  wire [2:0] cnt_idx = bus_addr[3:1];
  wire cnt_hi_sel = bus_addr[0];
  wire wr_ctrl = bus_wr & sel_ctrl;
  wire wr_run = bus_wr & sel_run;
  wire wr_flag = bus_wr & sel_flag;
  wire wr_ien = bus_wr & sel_ien;
  wire wr_cnt = bus_wr & sel_cnt;

  // clock enables: fast clock is the system clock itself
  wire fast_tick = 1'b1;
  wire slow_tick = (slow_cnt_q == TTB_SLOW_LAST);
  wire pre16_tick = (prescale_q == TTB_PRESCALE_LAST);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      slow_cnt_q <= 10'h000;
      prescale_q <= 4'h0;
    end else begin
      slow_cnt_q <= slow_tick ? 10'h000 : slow_cnt_q + 10'h001;
      prescale_q <= prescale_q + 4'h1;
    end
  end

  // external pins
  logic ext_fall;
  logic pm_rise, pm_fall;
  ttb_pin_sync u_ext_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin(timer4_ext_clock_pin),
    .level(),
    .rise(),
    .fall(ext_fall)
  );
  ttb_pin_sync u_pm_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin(pulse_measure_pin),
    .level(),
    .rise(pm_rise),
    .fall(pm_fall)
  );
  // timer 4 counts falling edges of the pin when selected
  wire t4_ext = timer_control_q[TTB_CTRL_T4_EXT];
  wire t4_tick = t4_ext ? ext_fall : fast_tick;
  wire [7:0] tmr_tick;
  assign tmr_tick = {fast_tick, fast_tick, fast_tick, t4_tick,
                     fast_tick, pre16_tick, slow_tick, slow_tick};

  // watchdog reloads on every rise of its run bit
  wire wd_run_rise = timer_run_enables_q[TTB_WDOG] & ~wd_run_prev_q;

  logic [7:0] cnt_lo [8];
  logic [7:0] cnt_hi [8];
  logic [7:0] tmo;
  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_tmr
      wire this_sel = wr_cnt & (cnt_idx == 3'(n));
      wire reload_n = (n == TTB_WDOG) ? wd_run_rise : 1'b0;
      ttb_timer u_tmr (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .tick(tmr_tick[n]),
        .run(timer_run_enables_q[n]),
        .wr_lo(this_sel & ~cnt_hi_sel),
        .wr_hi(this_sel & cnt_hi_sel),
        .reload(reload_n),
        .wdata(bus_wdata),
        .cnt_lo(cnt_lo[n]),
        .cnt_hi(cnt_hi[n]),
        .timeout(tmo[n])
      );
    end
  endgenerate

  // control registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_control_q <= TTB_CTRL_RST;
      timer_run_enables_q <= TTB_RUN_RST;
      timer_interrupt_enables_q <= TTB_IEN_RST;
      wd_run_prev_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        timer_control_q <= bus_wdata;
      end
      if (wr_run) begin
        timer_run_enables_q <= bus_wdata;
      end
      if (wr_ien) begin
        timer_interrupt_enables_q <= bus_wdata;
      end
      wd_run_prev_q <= timer_run_enables_q[TTB_WDOG];
    end
  end

  // flags: a timeout in the same cycle as the clear wins
  wire [7:0] flag_clr = wr_flag ? bus_wdata : 8'h00;
  wire [7:0] flags_d = (timer_interrupt_flags_q & ~flag_clr) | tmo;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_interrupt_flags_q <= TTB_FLAG_RST;
    end else begin
      timer_interrupt_flags_q <= flags_d;
    end
  end
  assign timer_irq = timer_interrupt_flags_q & timer_interrupt_enables_q;
  assign timer_irq_any = |timer_irq;

  // read mux, answered one cycle after the strobe
  wire [7:0] cnt_rd = cnt_hi_sel ? cnt_hi[cnt_idx] : cnt_lo[cnt_idx];
  wire [7:0] rd_mux = sel_ctrl ? timer_control_q :
                      sel_run ? timer_run_enables_q :
                      sel_flag ? timer_interrupt_flags_q :
                      sel_ien ? timer_interrupt_enables_q :
                      sel_cnt ? cnt_rd : 8'h00;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (bus_rd) begin
      rdata_q <= rd_mux;
    end
  end
  assign bus_rdata = rdata_q;

  // timer 4 output toggles at each timeout, driven only when enabled
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      t4_out_q <= 1'b0;
    end else if (tmo[TTB_BAUD_B]) begin
      t4_out_q <= ~t4_out_q;
    end
  end
  assign timer4_output_pin = t4_out_q;
  assign timer4_output_oe = timer_control_q[TTB_CTRL_T4_OUT];

  // baud source per UART
  wire [3:0] uart_sel = timer_control_q[TTB_CTRL_UART_LO +: 4];
  assign uart_baud_tick = (uart_sel & {4{tmo[TTB_BAUD_B]}})
                        | (~uart_sel & {4{tmo[TTB_BAUD_A]}});

  // pulse pin edge select
  wire [1:0] edge_sel = timer_control_q[TTB_CTRL_EDGE_LO +: 2];
  wire edge_hit = (edge_sel[0] & pm_rise) | (edge_sel[1] & pm_fall);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_event_q <= 1'b0;
    end else begin
      edge_event_q <= edge_hit;
    end
  end
  assign pulse_edge_event = edge_event_q;

  // watchdog restart pulse, held low until the second slow tick in hold
  wire wd_done = slow_tick & (wd_ticks_q == TTB_WD_PULSE_TICKS - 2'h1);
  always_comb begin
    wd_state_d = wd_state_q;
    unique case (wd_state_q)
      TTB_WD_IDLE: begin
        if (tmo[TTB_WDOG]) begin
          wd_state_d = TTB_WD_HOLD;
        end
      end
      TTB_WD_HOLD: begin
        if (wd_done) begin
          wd_state_d = TTB_WD_IDLE;
        end
      end
      default: begin
        wd_state_d = TTB_WD_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_state_q <= TTB_WD_IDLE;
      wd_ticks_q <= 2'h0;
    end else begin
      wd_state_q <= wd_state_d;
      if (wd_state_q != TTB_WD_HOLD) begin
        wd_ticks_q <= 2'h0;
      end else if (slow_tick) begin
        wd_ticks_q <= wd_ticks_q + 2'h1;
      end
    end
  end
  // open drain: only ever pulls low
  assign chip_reset_pin_o = 1'b0;
  assign chip_reset_pin_oe = (wd_state_q == TTB_WD_HOLD);

  a_flag_on_timeout: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (tmo != 8'h00) |=> ((timer_interrupt_flags_q & $past(tmo)) == $past(tmo)))
    else $error("timeout did not set its flag");
  a_flag_write_clear: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_flag && bus_wdata[2] && !tmo[2]) |=> !timer_interrupt_flags_q[2]
      ##1 (timer_interrupt_flags_q[2] == $past(tmo[2])))
    else $error("flag clear not a single pulse");
  a_flag_keep_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_flag && !bus_wdata[2] && timer_interrupt_flags_q[2])
      |=> timer_interrupt_flags_q[2])
    else $error("writing zero cleared a flag");
  a_irq_masked: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (timer_interrupt_enables_q == 8'h00) |-> !timer_irq_any)
    else $error("interrupt with all enables clear");
  a_wd_pull_low: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (tmo[TTB_WDOG] && wd_state_q == TTB_WD_IDLE)
      |=> chip_reset_pin_oe [*2])
    else $error("watchdog timeout did not pull reset");
  a_wd_pulse_len: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(chip_reset_pin_oe) |-> ($past(wd_ticks_q) == 2'h1 && $past(slow_tick)))
    else $error("restart pulse not two slow ticks");
  a_t4_clock_sel: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    t4_ext |-> (tmr_tick[TTB_BAUD_B] == ext_fall))
    else $error("timer 4 not on pin clock");
  a_read_counter: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (bus_rd && sel_cnt && !cnt_hi_sel && cnt_idx == 3'h5)
      |=> bus_rdata == $past(cnt_lo[5]))
    else $error("read did not return running counter");
  a_wd_rearm: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(timer_run_enables_q[TTB_WDOG]) |=>
      (cnt_lo[0] == g_tmr[0].u_tmr.lat_lo_q
       && cnt_hi[0] == g_tmr[0].u_tmr.lat_hi_q))
    else $error("watchdog run rise did not reload");
  a_reset_zero: assert property (
    @(posedge sys_clk)
    !rst_b |=> (!rst_b || timer_run_enables_q == 8'h00 || $past(wr_run)))
    else $error("run enables not zero after reset");

  c_any_timeout: cover property (@(posedge sys_clk) disable iff (!rst_b)
    tmo != 8'h00);
  c_wd_restart: cover property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(chip_reset_pin_oe));
  c_flag_set_clr: cover property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_flag && tmo != 8'h00));
endmodule : ttb_timer_bank
`default_nettype wire

/* File: hw/ttb_pkg.sv */
package ttb_pkg;
  // processor bus map, byte addresses
  localparam logic [15:0] TTB_CTRL_ADDR = 16'hdf42;
  localparam logic [15:0] TTB_RUN_ADDR = 16'hdf43;
  localparam logic [15:0] TTB_FLAG_ADDR = 16'hdf48;
  localparam logic [15:0] TTB_IEN_ADDR = 16'hdf49;
  // timer n low byte at base + 2n, high byte at base + 2n + 1
  localparam logic [11:0] TTB_CNT_BASE_HI = 12'h0df5;
  // reset values
  localparam logic [7:0] TTB_CTRL_RST = 8'h00;
  localparam logic [7:0] TTB_RUN_RST = 8'h00;
  localparam logic [7:0] TTB_FLAG_RST = 8'h00;
  localparam logic [7:0] TTB_IEN_RST = 8'h00;
  localparam logic [7:0] TTB_CNT_RST = 8'h00;
  // timer_control field positions
  localparam int TTB_CTRL_T4_EXT = 0;
  localparam int TTB_CTRL_T4_OUT = 1;
  localparam int TTB_CTRL_EDGE_LO = 2;
  localparam int TTB_CTRL_UART_LO = 4;
  // timer numbers with special roles
  localparam int TTB_WDOG = 0;
  localparam int TTB_BAUD_A = 3;
  localparam int TTB_BAUD_B = 4;
  // clock rates
  localparam int TTB_SYS_CLK_HZ = 20000000;
  localparam int TTB_SLOW_CLK_HZ = 32768;
  localparam int TTB_SLOW_DIV = TTB_SYS_CLK_HZ / TTB_SLOW_CLK_HZ;
  localparam logic [9:0] TTB_SLOW_LAST = 10'(TTB_SLOW_DIV - 1);
  localparam logic [3:0] TTB_PRESCALE_LAST = 4'hf;
  // watchdog restart pulse, in slow clock cycles
  localparam logic [1:0] TTB_WD_PULSE_TICKS = 2'h2;
  typedef enum logic [1:0] {
    TTB_WD_IDLE = 2'b01,
    TTB_WD_HOLD = 2'b10
  } ttb_wd_e;
endpackage : ttb_pkg

/* File: hw/ttb_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ttb_pin_sync
  import ttb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_q, s2_q, s3_q, level_q;
  wire agree = (s2_q == s3_q);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        level_q <= s2_q;
      end
    end
  end
  // a change counts only once two stages agree, filtering one-cycle glitches
  assign level = level_q;
  assign rise = agree & s2_q & ~level_q;
  assign fall = agree & ~s2_q & level_q;
endmodule : ttb_pin_sync
`default_nettype wire

/* File: hw/ttb_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ttb_timer
  import ttb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic run,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic reload,
  input wire logic [7:0] wdata,
  output logic [7:0] cnt_lo,
  output logic [7:0] cnt_hi,
  output logic timeout
);
  logic [7:0] lat_lo_q, lat_hi_q, cnt_lo_q, cnt_hi_q;
  wire step = tick & run;
  wire at_zero = (cnt_lo_q == 8'h00) & (cnt_hi_q == 8'h00);
  wire expire = step & at_zero;
  // a high-byte write loads the counters from the new high latch
  wire [7:0] lat_hi_d = wr_hi ? wdata : lat_hi_q;
  wire [7:0] lat_lo_d = wr_lo ? wdata : lat_lo_q;
  wire load_all = wr_hi | reload | expire;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lat_lo_q <= TTB_CNT_RST;
      lat_hi_q <= TTB_CNT_RST;
    end else begin
      lat_lo_q <= lat_lo_d;
      lat_hi_q <= lat_hi_d;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_lo_q <= TTB_CNT_RST;
      cnt_hi_q <= TTB_CNT_RST;
    end else if (load_all) begin
      cnt_lo_q <= lat_lo_d;
      cnt_hi_q <= lat_hi_d;
    end else if (step) begin
      cnt_lo_q <= cnt_lo_q - 8'h01;
      if (cnt_lo_q == 8'h00) begin
        cnt_hi_q <= cnt_hi_q - 8'h01;
      end
    end
  end
  assign cnt_lo = cnt_lo_q;
  assign cnt_hi = cnt_hi_q;
  assign timeout = expire;

  a_lo_write_only: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_lo && !load_all && !step) |=> ($stable(cnt_lo_q) && $stable(cnt_hi_q)))
    else $error("low byte write disturbed the counters");
  a_hi_write_load: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    wr_hi |=> (cnt_hi_q == $past(wdata) && cnt_lo_q == lat_lo_q))
    else $error("high byte write did not load counters");
  a_count_down: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (step && !at_zero && !wr_hi && !reload)
      |=> cnt_lo_q == $past(cnt_lo_q) - 8'h01)
    else $error("low counter did not decrement");
  a_expire_reload: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    expire |=> (cnt_lo_q == lat_lo_q && cnt_hi_q == lat_hi_q))
    else $error("timeout did not reload from latches");
endmodule : ttb_timer
`default_nettype wire

/* File: dv/ttb_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ttb_cpu_model (
  input wire logic sys_clk,
  output logic [15:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata
);
  initial begin
    bus_addr = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
  end

  // one strobe cycle per access; stale data inverted so it is never reused
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd
endmodule : ttb_cpu_model
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ttb_pkg::*;
  logic sys_clk, rst_b, t4_pin, pulse_pin;
  logic [15:0] bus_addr;
  logic bus_wr, bus_rd;
  logic [7:0] bus_wdata, bus_rdata, irq, v;
  logic t4_out, t4_oe, rst_o, rst_oe, irq_any, edge_ev, wd_seen, a;
  logic [3:0] baud;
  logic [7:0] edge_exp [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int nb = 0;
  int ne = 0;
  int t0, t1, n;

  ttb_timer_bank u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .timer4_ext_clock_pin(t4_pin), .pulse_measure_pin(pulse_pin),
    .timer4_output_pin(t4_out), .timer4_output_oe(t4_oe),
    .chip_reset_pin_o(rst_o), .chip_reset_pin_oe(rst_oe),
    .timer_irq(irq), .timer_irq_any(irq_any), .uart_baud_tick(baud),
    .pulse_edge_event(edge_ev));
  ttb_cpu_model u_cpu (.sys_clk(sys_clk), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (baud[0] === 1'b1) nb <= nb + 1;
    if (edge_ev === 1'b1) ne <= ne + 1;
    if (!rst_b) wd_seen <= 1'b0;
    else if (rst_oe === 1'b1) wd_seen <= 1'b1;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rchk(input logic [15:0] ad, input logic [7:0] e);
    u_cpu.rd(ad, v);
    chk($sformatf("read %h", ad), {8'h00, e}, {8'h00, v});
  endtask : rchk

  function automatic logic [15:0] lo_a(input int k);
    return {TTB_CNT_BASE_HI, 4'h0} + 16'(2 * k);
  endfunction : lo_a

  task automatic cycles(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cycles

  // baud ticks are one-cycle pulses, so look at them mid-cycle
  task automatic wait_baud(output int t);
    t = -1;
    for (int i = 0; i < 2000; i++) begin
      @(negedge sys_clk);
      if (baud[0] === 1'b1) begin
        t = cyc;
        break;
      end
    end
  endtask : wait_baud

  initial begin
    rst_b = 1'b0;
    t4_pin = 1'b0;
    pulse_pin = 1'b0;
    cycles(16);
    rst_b <= 1'b1;
    rchk(TTB_CTRL_ADDR, TTB_CTRL_RST);
    rchk(TTB_RUN_ADDR, TTB_RUN_RST);
    rchk(TTB_FLAG_ADDR, TTB_FLAG_RST);
    rchk(TTB_IEN_ADDR, TTB_IEN_RST);
    rchk(16'hdf44, 8'h00);
    u_cpu.wr(TTB_CTRL_ADDR, 8'ha5);
    rchk(TTB_CTRL_ADDR, 8'ha5);
    u_cpu.wr(TTB_CTRL_ADDR, 8'h00);
    for (int k = 0; k < 8; k++) begin
      u_cpu.wr(lo_a(k), 8'h30 + 8'(k));
      u_cpu.wr(lo_a(k) + 16'h0001, 8'h10 + 8'(k));
    end
    for (int k = 0; k < 8; k++) begin
      rchk(lo_a(k), 8'h30 + 8'(k));
      rchk(lo_a(k) + 16'h0001, 8'h10 + 8'(k));
    end
    u_cpu.wr(lo_a(2), 8'h99);
    rchk(lo_a(2), 8'h32);
    u_cpu.wr(lo_a(2) + 16'h0001, 8'h00);
    rchk(lo_a(2), 8'h99);
    // prescaled timer, three ticks of sixteen cycles each
    u_cpu.wr(lo_a(2), 8'h02);
    u_cpu.wr(lo_a(2) + 16'h0001, 8'h00);
    u_cpu.wr(TTB_IEN_ADDR, 8'h04);
    u_cpu.wr(TTB_RUN_ADDR, 8'h04);
    cycles(30);
    chk("t2 early", 16'h0000, {15'h0000, irq[2]});
    cycles(30);
    chk("t2 due", 16'h0001, {15'h0000, irq[2]});
    chk("irq any", 16'h0001, {15'h0000, irq_any});
    u_cpu.wr(TTB_RUN_ADDR, 8'h00);
    rchk(TTB_FLAG_ADDR, 8'h04);
    u_cpu.wr(TTB_IEN_ADDR, 8'h00);
    cycles(1);
    chk("masked", 16'h0000, {8'h00, irq});
    u_cpu.wr(TTB_FLAG_ADDR, 8'h00);
    rchk(TTB_FLAG_ADDR, 8'h04);
    u_cpu.wr(TTB_FLAG_ADDR, 8'h04);
    rchk(TTB_FLAG_ADDR, 8'h00);
    u_cpu.wr(lo_a(2) + 16'h0001, 8'h00);
    // timer 3 with both bytes in play: period is latch plus one
    u_cpu.wr(lo_a(3), 8'h02);
    u_cpu.wr(lo_a(3) + 16'h0001, 8'h01);
    u_cpu.wr(TTB_RUN_ADDR, 8'h08);
    wait_baud(t0);
    chk("baud t3", 16'h000f, {12'h000, baud});
    wait_baud(t1);
    chk("t3 period", 16'h0103, 16'(t1 - t0));
    u_cpu.wr(lo_a(4), 8'h04);
    u_cpu.wr(lo_a(4) + 16'h0001, 8'h00);
    u_cpu.wr(TTB_CTRL_ADDR, 8'hf2);
    u_cpu.wr(TTB_RUN_ADDR, 8'h10);
    wait_baud(t0);
    chk("baud t4", 16'h000f, {12'h000, baud});
    wait_baud(t1);
    chk("t4 period", 16'h0005, 16'(t1 - t0));
    chk("t4 oe", 16'h0001, {15'h0000, t4_oe});
    // mixed select: uarts 0 and 2 on timer 4, timer 3 is stopped
    u_cpu.wr(TTB_CTRL_ADDR, 8'h52);
    wait_baud(t1);
    chk("baud mix", 16'h0005, {12'h000, baud});
    cycles(2);
    a = t4_out;
    wait_baud(t1);
    cycles(2);
    chk("t4 toggle", {15'h0000, ~a}, {15'h0000, t4_out});
    // external clock: idle pin must freeze timer 4
    u_cpu.wr(TTB_CTRL_ADDR, 8'hf3);
    u_cpu.wr(lo_a(4) + 16'h0001, 8'h00);
    n = nb;
    cycles(40);
    chk("ext idle", 16'h0000, 16'(nb - n));
    for (int k = 0; k < 5; k++) begin
      t4_pin <= 1'b1;
      cycles(6);
      t4_pin <= 1'b0;
      cycles(6);
    end
    cycles(10);
    chk("ext count", 16'h0001, 16'(nb - n));
    for (int m = 0; m < 4; m++) begin
      u_cpu.wr(TTB_CTRL_ADDR, {4'h0, 2'(m), 2'b00});
      n = ne;
      pulse_pin <= 1'b1;
      cycles(10);
      pulse_pin <= 1'b0;
      cycles(10);
      chk("edges", {8'h00, edge_exp[m]}, 16'(ne - n));
    end
    chk("no restart", 16'h0000, {15'h0000, wd_seen});
    u_cpu.wr(lo_a(0), 8'h01);
    u_cpu.wr(lo_a(0) + 16'h0001, 8'h00);
    u_cpu.wr(TTB_RUN_ADDR, 8'h01);
    t0 = -1;
    for (int i = 0; i < 3000 && t0 < 0; i++) begin
      @(negedge sys_clk);
      if (rst_oe === 1'b1) t0 = cyc;
    end
    u_cpu.wr(TTB_RUN_ADDR, 8'h00);
    t1 = -1;
    for (int i = 0; i < 1500 && t1 < 0; i++) begin
      @(negedge sys_clk);
      if (rst_oe === 1'b0) t1 = cyc;
    end
    chk("rst level", 16'h0000, {15'h0000, rst_o});
    chk("rst width", 16'h0001,
        {15'h0000, t0 >= 0 && t1 - t0 == 2 * TTB_SLOW_DIV});
    tally_and_finish();
  end

  initial begin
    #2_000_000;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
